// ---- hw/area_select.sv ----
`timescale 1ns/1ps
module area_select
    import area_sel_pkg::*;
#(
    parameter int WIN_CYC = SPEED_WIN_CYC    // Speed window length in cycles
) (
    input wire logic i_clk,                  // System clock, 250 MHz
    input wire logic i_rst_n,                // Async reset, active low
    input wire logic [SEL_PINS-1:0] i_sel,   // Selection pairs, bit 2p true, 2p+1 complement
    input wire sel_mode_t i_mode,            // Selection mode
    input wire logic i_mute_en,              // Muting active
    input wire logic i_fault_clr,            // Clear latched travel fault
    input wire logic [N_ENC-1:0] i_enc_a,    // Encoder phase A inputs
    input wire logic [N_ENC-1:0] i_enc_b,    // Encoder phase B inputs
    output logic [AREA_W-1:0] o_area,        // Active area number, 0 = none
    output logic o_area_valid,               // Area number is valid
    output logic o_area_chg,                 // Pulse on area change
    output logic o_sel_invalid,              // Selection pattern invalid, level
    output logic o_sel_fault,                // Pulse on entry into invalid pattern
    output logic o_travel_fault,             // Pulse on abnormal travel
    output logic o_travel_stop,              // Latched stop request
    output logic [N_ENC-1:0] o_dir_fwd,      // Direction per encoder
    output logic [SPEED_W-1:0] o_speed_0,    // Encoder 0 speed
    output logic [SPEED_W-1:0] o_speed_1     // Encoder 1 speed
);

    typedef struct packed {
        // Selection synchronisers
        logic [SEL_PINS-1:0] sel_s1;
        logic [SEL_PINS-1:0] sel_s2;
        // Speed window timer
        logic [WIN_W-1:0] win_cnt;
        logic win_tick;
        logic eval_tick;
        // Travel supervision
        trv_state_t trv;
        // Registered outputs
        logic [AREA_W-1:0] area;
        logic area_valid;
        logic area_chg;
        logic sel_invalid;
        logic sel_fault;
        logic trv_fault;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic [N_ENC-1:0] dir_fwd;
    logic [SPEED_W-1:0] speed [N_ENC];

    // ****************************************
    // Helpers
    // ****************************************
    // Count of ones in an eight-bit pattern
    function automatic int popc(input logic [7:0] v);
        int n;
        int b;
        n = 0;
        for (b = 0; b < 8; b++) begin
            n = n + int'(v[b]);
        end
        return n;
    endfunction : popc

    // Area = 1 + number of valid patterns of larger value
    function automatic logic [AREA_W-1:0] rank(input logic [7:0] v, input int nbits, input int k);
        int cnt;
        int i;
        cnt = 0;
        for (i = 0; i < 256; i++) begin
            if (i < (1 << nbits) && popc(8'(i)) == k && i > int'(v)) begin
                cnt = cnt + 1;
            end
        end
        return AREA_W'(cnt + 1);
    endfunction : rank

    // ****************************************
    // Encoder channels
    // ****************************************
    // Each encoder has its own pair of phase inputs
    generate
        for (genvar e = 0; e < N_ENC; e++) begin : g_enc
            enc_channel u_chan (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_phase_a(i_enc_a[e]),
                .i_phase_b(i_enc_b[e]),
                .i_win_tick(st.win_tick),
                .o_dir_fwd(dir_fwd[e]),
                .o_speed(speed[e])
            );
        end
    endgenerate

    // ****************************************
    // Decode and supervision
    // ****************************************
    // Selection decode
    logic [1:0] pair_e;
    logic [7:0] vec;
    int nbits;
    int k;
    logic pat_ok;
    logic [AREA_W-1:0] sel_area;

    // Encoder area and supervision
    logic [SPEED_W-1:0] spd_max;
    logic [AREA_W-1:0] enc_area;
    logic mov0;
    logic mov1;
    logic dir_clash;
    logic dead_0;
    logic dead_1;
    logic trv_bad;

    // Chosen area source
    logic [AREA_W-1:0] new_area;
    logic new_valid;

    // Pattern vector per mode, A true in bit 0
    always_comb begin
        // Pair E, the muting substitute
        pair_e = st.sel_s2[PAIR_E_LSB+:2];
        vec = 8'h00;
        nbits = 8;
        k = 4;
        case (i_mode)
            MODE_SEL8: begin
                // All four pairs in use
                vec = st.sel_s2[7:0];
                nbits = 8;
                k = 4;
            end
            MODE_SEL6: begin
                // Pair E replaces pair C while muted
                vec = {2'h0, (i_mute_en ? pair_e : st.sel_s2[5:4]),
                       st.sel_s2[3:0]};
                nbits = 6;
                k = 3;
            end
            MODE_SEL4: begin
                // Pair E replaces pair B while muted
                vec = {4'h0, (i_mute_en ? pair_e : st.sel_s2[3:2]),
                       st.sel_s2[1:0]};
                nbits = 4;
                k = 2;
            end
            MODE_SEL2: begin
                // Single pair only
                vec = {6'h00, st.sel_s2[1:0]};
                nbits = 2;
                k = 1;
            end
            default: begin
                // Unused codes decode as invalid
                vec = 8'h00;
                nbits = 8;
                k = 4;
            end
        endcase
        // Exactly k inputs on, then rank
        pat_ok = (popc(vec) == k);
        sel_area = rank(vec, nbits, k);
    end

    // ****************************************
    // Speed band and travel supervision
    // ****************************************
    // Speed band to area, faster encoder counts
    always_comb begin
        spd_max = (speed[0] > speed[1]) ? speed[0] : speed[1];
        // Band limits rise with speed
        if (spd_max < BAND_LIM_1) begin
            enc_area = 8'h01;
        end else if (spd_max < BAND_LIM_2) begin
            enc_area = 8'h02;
        end else if (spd_max < BAND_LIM_3) begin
            enc_area = 8'h03;
        end else begin
            enc_area = 8'h04;
        end
        // Moving means one edge or more per window
        mov0 = speed[0] >= SPEED_MOVE_MIN;
        mov1 = speed[1] >= SPEED_MOVE_MIN;
        // Both turning, but not the same way
        dir_clash = mov0 && mov1 && (dir_fwd[0] != dir_fwd[1]);
        // One shaft still while the other runs
        dead_0 = !mov0 && (speed[1] >= BAND_LIM_1);
        dead_1 = !mov1 && (speed[0] >= BAND_LIM_1);
        trv_bad = dir_clash || dead_0 || dead_1;
    end

    // ****************************************
    // Area source and travel state
    // ****************************************
    // Next state of the whole block
    always_comb begin
        next_st = st;
        // Selection synchronisers, two stages
        next_st.sel_s1 = i_sel;
        next_st.sel_s2 = st.sel_s1;
        // One-cycle pulses rest low
        next_st.sel_fault = 1'b0;
        next_st.trv_fault = 1'b0;
        next_st.area_chg = 1'b0;

        // Speed window timer
        if (st.win_cnt >= WIN_W'(WIN_CYC - 1)) begin
            next_st.win_cnt = '0;
            next_st.win_tick = 1'b1;
        end else begin
            next_st.win_cnt = st.win_cnt + 32'h00000001;
            next_st.win_tick = 1'b0;
        end
        // Delayed tick, aligned with fresh speeds
        next_st.eval_tick = st.win_tick;

        // Area source
        if (i_mode == MODE_ENC) begin
            // Encoder speed decides
            new_area = enc_area;
            new_valid = 1'b1;
            next_st.sel_invalid = 1'b0;
        end else if (pat_ok) begin
            // Valid selection pattern
            new_area = sel_area;
            new_valid = 1'b1;
            next_st.sel_invalid = 1'b0;
        end else begin
            // No match: fault event, no area
            new_area = AREA_RST;
            new_valid = 1'b0;
            next_st.sel_invalid = 1'b1;
            next_st.sel_fault = ~st.sel_invalid;
        end

        // Registered area and its change pulse
        next_st.area = new_area;
        next_st.area_valid = new_valid;
        next_st.area_chg = new_valid && (new_area != st.area || !st.area_valid);

        // Travel supervision, judged once per window while stopped or moving; a fault clear acts on any cycle
        case (st.trv)
            TRV_STOP: begin
                // First movement or abnormal start
                if (st.eval_tick && trv_bad) begin
                    next_st.trv = TRV_FAULT;
                    next_st.trv_fault = 1'b1;
                end else if (st.eval_tick && (mov0 || mov1)) begin
                    next_st.trv = TRV_MOVE;
                end
            end
            TRV_MOVE: begin
                // Stop when both shafts rest
                if (st.eval_tick && trv_bad) begin
                    next_st.trv = TRV_FAULT;
                    next_st.trv_fault = 1'b1;
                end else if (st.eval_tick && !mov0 && !mov1) begin
                    next_st.trv = TRV_STOP;
                end
            end
            TRV_FAULT: begin
                // Leave only on a clean clear
                if (i_fault_clr && !trv_bad) begin
                    next_st.trv = TRV_STOP;
                end
            end
            default: begin
                // Unknown code fails safe
                next_st.trv = TRV_FAULT;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Selection results
    assign o_area = st.area;
    assign o_area_valid = st.area_valid;
    assign o_area_chg = st.area_chg;
    assign o_sel_invalid = st.sel_invalid;
    assign o_sel_fault = st.sel_fault;

    // Travel supervision
    assign o_travel_fault = st.trv_fault;
    assign o_travel_stop = (st.trv == TRV_FAULT);

    // Encoder measurements
    assign o_dir_fwd = dir_fwd;
    assign o_speed_0 = speed[0];
    assign o_speed_1 = speed[1];

endmodule : area_select

// ---- hw/area_sel_pkg.sv ----
// Function
// - Eight-input mode: four of eight on; rank of pattern, largest value is area 1.
// - Six-input mode: three of six on, twenty areas ranked the same way.
// - Four-input mode: two of four on, six areas ranked the same way.
// - Two-input mode: one of the pair on; complement alone is area 1.
// - Muting in six or four mode reads pair E in place of top pair.
// - Two independent quadrature encoders, each on its own phase A/B inputs.
// - Encoder mode takes the area from measured encoder speed, not selection inputs.
// - Rising phase A with phase B high records forward direction.
// - Rising phase A with phase B low records backward direction.
// - Watch speed and direction of both encoders; flag abnormal travel to stop.
package area_sel_pkg;

    // ****************************************
    // Modes and states
    // ****************************************
    typedef enum logic [2:0] {
        MODE_SEL8 = 3'h0,
        MODE_SEL6 = 3'h1,
        MODE_SEL4 = 3'h3,
        MODE_SEL2 = 3'h2,
        MODE_ENC = 3'h6
    } sel_mode_t;

    typedef enum logic [1:0] {
        TRV_STOP = 2'h0,
        TRV_MOVE = 2'h1,
        TRV_FAULT = 2'h3
    } trv_state_t;

    // ****************************************
    // Sizes and field positions
    // ****************************************
    localparam int SEL_PINS = 10;
    localparam int AREA_W = 8;
    localparam int SPEED_W = 16;
    localparam int N_ENC = 2;
    localparam int WIN_W = 32;
    localparam int PAIR_E_LSB = 8;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [AREA_W-1:0] AREA_RST = 8'h00;
    localparam logic [SPEED_W-1:0] SPEED_RST = 16'h0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SPEED_WIN_US = 1000;
    localparam int SPEED_WIN_CYC = SPEED_WIN_US * 1000000 / CLK_PERIOD_PS;

    // ****************************************
    // Speed bands, rising edges per window
    // ****************************************
    localparam logic [SPEED_W-1:0] SPEED_MOVE_MIN = 16'h0001;
    localparam logic [SPEED_W-1:0] BAND_LIM_1 = 16'h000a;
    localparam logic [SPEED_W-1:0] BAND_LIM_2 = 16'h001e;
    localparam logic [SPEED_W-1:0] BAND_LIM_3 = 16'h003c;
    localparam logic [SPEED_W-1:0] SPEED_SAT = 16'hffff;

endpackage : area_sel_pkg

// ---- hw/enc_channel.sv ----
`timescale 1ns/1ps
module enc_channel
    import area_sel_pkg::*;
(
    input wire logic i_clk,                  // System clock
    input wire logic i_rst_n,                // Async reset, active low
    input wire logic i_phase_a,              // Encoder phase A, asynchronous
    input wire logic i_phase_b,              // Encoder phase B, asynchronous
    input wire logic i_win_tick,             // End of speed window
    output logic o_dir_fwd,                  // Last direction, 1 = forward
    output logic [SPEED_W-1:0] o_speed       // Rising edges in last window
);

    typedef struct packed {
        logic a_s1;
        logic a_s2;
        logic a_s3;
        logic b_s1;
        logic b_s2;
        logic dir_fwd;
        logic [SPEED_W-1:0] cnt;
        logic [SPEED_W-1:0] speed;
    } chan_state_t;

    chan_state_t st;
    chan_state_t next_st;
    logic rise_a;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        // Two-flop synchronisers; stage two feeds logic, plus a third A stage for edge detect
        next_st.a_s1 = i_phase_a;
        next_st.a_s2 = st.a_s1;
        next_st.a_s3 = st.a_s2;
        next_st.b_s1 = i_phase_b;
        next_st.b_s2 = st.b_s1;
        rise_a = st.a_s2 & ~st.a_s3;
        // Phase B level at phase A rising edge gives direction
        if (rise_a) begin
            next_st.dir_fwd = st.b_s2;
        end
        // Window count, saturating
        if (i_win_tick) begin
            next_st.speed = st.cnt;
            next_st.cnt = SPEED_RST;
        end
        if (rise_a && next_st.cnt != SPEED_SAT) begin
            next_st.cnt = next_st.cnt + 16'h0001;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_dir_fwd = st.dir_fwd;
    assign o_speed = st.speed;

endmodule : enc_channel

// ---- dv/area_select_monitor.sv ----
`timescale 1ns/1ps
// ****
// Area select port checker
// ****
module area_select_monitor
    import area_sel_pkg::*;
#(
    parameter int WIN_CYC = SPEED_WIN_CYC
) (
    input wire logic i_clk,                  // Clock
    input wire logic i_rst_n,                // Reset
    input wire logic [SEL_PINS-1:0] i_sel,   // Pairs
    input wire sel_mode_t i_mode,            // Mode
    input wire logic i_mute_en,              // Muting
    input wire logic i_fault_clr,            // Clear
    input wire logic [N_ENC-1:0] i_enc_a,    // Phase A
    input wire logic [N_ENC-1:0] i_enc_b,    // Phase B
    input wire logic [AREA_W-1:0] o_area,    // Area
    input wire logic o_area_valid,           // Valid
    input wire logic o_area_chg,             // Change
    input wire logic o_sel_invalid,          // Invalid
    input wire logic o_sel_fault,            // Fault pulse
    input wire logic o_travel_fault,         // Travel pulse
    input wire logic o_travel_stop,          // Stop
    input wire logic [N_ENC-1:0] o_dir_fwd,  // Direction
    input wire logic [SPEED_W-1:0] o_speed_0, // Speed 0
    input wire logic [SPEED_W-1:0] o_speed_1  // Speed 1
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Selection decode relations
    chk_invalid_zero: assert property (o_sel_invalid |-> o_area == 8'h00 && !o_area_valid)
        else $error("invalid pattern shows an area");
    chk_fault_once: assert property (o_sel_fault |-> o_sel_invalid ##1 !o_sel_fault)
        else $error("selection fault pulse wrong");
    chk_valid_pair: assert property (o_area_valid == (o_area != 8'h00))
        else $error("valid flag disagrees with area");
    chk_chg_pulse: assert property (o_area_chg == (o_area_valid && $changed(o_area)))
        else $error("area change pulse wrong");
    chk_sel_sync: assert property ((($stable(i_sel) && $stable(i_mode) && $stable(i_mute_en)
        && i_mode != MODE_ENC) [*5] ##1 ($stable(i_mode) && $stable(i_mute_en)) [*2])
        |-> $stable(o_area) [*2])
        else $error("area reacts before two sync stages");
    chk_fault_rise: assert property ($rose(o_sel_invalid) |-> o_sel_fault)
        else $error("no fault pulse on invalid entry");
    // Encoder path relations
    chk_enc_area: assert property ((i_mode == MODE_ENC) [*4]
        |=> o_area_valid && !o_sel_invalid && o_area inside {[8'h01:8'h04]})
        else $error("encoder mode area out of range");
    chk_stop_rise: assert property ($rose(o_travel_stop) |-> o_travel_fault)
        else $error("no travel pulse on stop entry");
    chk_dir_fwd: assert property ($rose(i_enc_a[0]) && i_enc_b[0] |-> ##[4:5] o_dir_fwd[0])
        else $error("forward direction not recorded");
    chk_dir_back: assert property ($rose(i_enc_a[1]) && !i_enc_b[1] |-> ##[4:5] !o_dir_fwd[1])
        else $error("backward direction not recorded");
    chk_stop_hold: assert property (o_travel_stop && !i_fault_clr |=> o_travel_stop)
        else $error("stop dropped without clear");
    chk_fault_entry: assert property (o_travel_fault |=> !o_travel_fault && o_travel_stop)
        else $error("travel fault pulse wrong");
    cover property (o_sel_fault);
    cover property (o_travel_fault);
    cover property (o_area_chg && i_mode == MODE_ENC);
endmodule : area_select_monitor

bind area_select area_select_monitor #(.WIN_CYC(WIN_CYC)) mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_sel(i_sel), .i_mode(i_mode), .i_mute_en(i_mute_en), .i_fault_clr(i_fault_clr),
    .i_enc_a(i_enc_a), .i_enc_b(i_enc_b), .o_area(o_area), .o_area_valid(o_area_valid),
    .o_area_chg(o_area_chg), .o_sel_invalid(o_sel_invalid), .o_sel_fault(o_sel_fault),
    .o_travel_fault(o_travel_fault), .o_travel_stop(o_travel_stop), .o_dir_fwd(o_dir_fwd),
    .o_speed_0(o_speed_0), .o_speed_1(o_speed_1));

// ---- dv/enc_model.sv ----
`timescale 1ns/1ps
// ****
// Quadrature encoder stand-in
// ****
module enc_model (
    input wire logic i_clk,           // Bench clock
    input wire logic i_run,           // Shaft turning
    input wire logic i_fwd,           // 1 = forward
    input wire logic [7:0] i_quarter, // Cycles per quarter
    output logic o_a,                 // Phase A
    output logic o_b                  // Phase B
);
    logic [7:0] cnt = 8'h00;
    logic [1:0] ph = 2'h0;
    // Step the Gray phase; a stopped shaft holds its level
    always @(posedge i_clk) begin
        if (i_run && cnt + 8'h01 >= i_quarter) begin
            cnt <= 8'h00;
            ph <= i_fwd ? ph + 2'h1 : ph - 2'h1;
        end else if (i_run) begin
            cnt <= cnt + 8'h01;
        end
    end
    // Forward: B rises a quarter period ahead of A
    assign o_a = ph[1];
    assign o_b = ph[1] ^ ph[0];
endmodule : enc_model

// ---- dv/area_select_tb.sv ----
`timescale 1ns/1ps
// ****
// Area select bench
// ****
module area_select_tb;
    import area_sel_pkg::*;
    localparam int WC = 1024;
    logic i_clk, i_rst_n, i_mute_en, i_fault_clr, stopped;
    logic [SEL_PINS-1:0] i_sel;
    sel_mode_t i_mode;
    wire [N_ENC-1:0] i_enc_a, i_enc_b;
    logic [N_ENC-1:0] run, fwd, o_dir_fwd;
    logic [7:0] qq, o_area;
    logic o_area_valid, o_area_chg, o_sel_invalid, o_sel_fault, o_travel_fault, o_travel_stop;
    logic [15:0] o_speed_0, o_speed_1, lfsr;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    sel_mode_t mt[4] = '{MODE_SEL8, MODE_SEL6, MODE_SEL4, MODE_SEL2};
    int nb[4] = '{8, 6, 4, 2};
    logic [15:0] last[4] = '{16'h0046, 16'h0014, 16'h0006, 16'h0002};

    area_select #(.WIN_CYC(WC)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sel(i_sel), .i_mode(i_mode),
        .i_mute_en(i_mute_en), .i_fault_clr(i_fault_clr), .i_enc_a(i_enc_a), .i_enc_b(i_enc_b),
        .o_area(o_area), .o_area_valid(o_area_valid), .o_area_chg(o_area_chg),
        .o_sel_invalid(o_sel_invalid), .o_sel_fault(o_sel_fault), .o_travel_fault(o_travel_fault),
        .o_travel_stop(o_travel_stop), .o_dir_fwd(o_dir_fwd), .o_speed_0(o_speed_0), .o_speed_1(o_speed_1));
    enc_model em0 (.i_clk(i_clk), .i_run(run[0]), .i_fwd(fwd[0]), .i_quarter(qq), .o_a(i_enc_a[0]),
        .o_b(i_enc_b[0]));
    enc_model em1 (.i_clk(i_clk), .i_run(run[1]), .i_fwd(fwd[1]), .i_quarter(qq), .o_a(i_enc_a[1]),
        .o_b(i_enc_b[1]));

    // Clock
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand

    // Rank among k-of-n patterns, largest value first
    function automatic logic [7:0] exp_area(input logic [7:0] v, input int n);
        int r;
        r = 1;
        if ($countones(v) != n / 2) return 8'h00;
        for (int u = 0; u < (1 << n); u++) if ($countones(u[7:0]) == n / 2 && u > int'(v)) r++;
        return r[7:0];
    endfunction : exp_area

    function automatic logic [7:0] band(input logic [15:0] s);
        if (s < BAND_LIM_1) return 8'h01;
        if (s < BAND_LIM_2) return 8'h02;
        if (s < BAND_LIM_3) return 8'h03;
        return 8'h04;
    endfunction : band

    task automatic cmp_num(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp_num

    task automatic cmp_flag(input logic got, input logic exp, input string what);
        cmp_num({15'h0000, got}, {15'h0000, exp}, what);
    endtask : cmp_flag

    task automatic sel_case(input int i, input logic mute, input logic [9:0] v);
        logic [7:0] eff;
        logic [7:0] e;
        eff = v[7:0];
        if (mute && i == 1) eff[5:4] = v[9:8];
        if (mute && i == 2) eff[3:2] = v[9:8];
        eff = eff & ((8'h01 << nb[i]) - 8'h01);
        e = exp_area(eff, nb[i]);
        @(posedge i_clk);
        i_mode <= mt[i];
        i_mute_en <= mute;
        i_sel <= v;
        repeat (6) @(posedge i_clk);
        #1;
        cmp_num({8'h00, o_area}, {8'h00, e}, "area");
        cmp_flag(o_sel_invalid, e == 8'h00, "invalid");
        cmp_flag(o_area_valid, e != 8'h00, "valid");
    endtask : sel_case

    task automatic enc_case(input logic [1:0] r, input logic [1:0] f, input logic [7:0] q, input string nm);
        logic [15:0] s0, s1;
        s0 = r[0] ? 16'(WC / (4 * q)) : 16'h0000;
        s1 = r[1] ? 16'(WC / (4 * q)) : 16'h0000;
        stopped = stopped | (s0 != 0 && s1 != 0 && f[0] != f[1]) | (s0 == 0 && s1 >= 16'h000a)
            | (s1 == 0 && s0 >= 16'h000a);
        lfsr = next_rand(lfsr);
        @(posedge i_clk);
        run <= r;
        fwd <= f;
        qq <= q;
        i_mode <= MODE_ENC;
        i_sel <= lfsr[9:0];
        repeat (3 * WC) @(posedge i_clk);
        #1;
        cmp_num(o_speed_0, s0, "speed 0");
        cmp_num(o_speed_1, s1, "speed 1");
        cmp_num({8'h00, o_area}, {8'h00, band(s0 > s1 ? s0 : s1)}, "enc area");
        cmp_flag(o_area_valid, 1'b1, "enc valid");
        cmp_num({14'h0000, o_dir_fwd & r}, {14'h0000, f & r}, "direction");
        cmp_flag(o_travel_stop, stopped, "stop");
        $display("done %s", nm);
    endtask : enc_case

    task automatic clear_fault;
        @(posedge i_clk);
        run <= 2'b00;
        repeat (3 * WC) @(posedge i_clk);
        i_fault_clr <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_fault_clr <= 1'b0;
        stopped = 1'b0;
        @(posedge i_clk);
        #1;
        cmp_flag(o_travel_stop, 1'b0, "stop cleared");
        $display("done clear fault");
    endtask : clear_fault

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // Hang guard
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            $display("unexpected at %0t: timeout", $time);
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        logic [7:0] m;
        logic mu;
        i_rst_n = 1'b0;
        i_sel = '0;
        i_mode = MODE_SEL8;
        i_mute_en = 1'b0;
        i_fault_clr = 1'b0;
        run = 2'b00;
        fwd = 2'b00;
        qq = 8'h04;
        lfsr = 16'h0046;
        stopped = 1'b0;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            m = (8'h01 << nb[i]) - 8'h01;
            sel_case(i, 1'b0, {2'b00, m ^ ((8'h01 << (nb[i] / 2)) - 8'h01)});
            sel_case(i, 1'b0, {2'b00, (8'h01 << (nb[i] / 2)) - 8'h01});
            cmp_num({8'h00, o_area}, last[i], "last area");
            sel_case(i, 1'b0, {2'b00, m});
            for (int j = 0; j < 40; j++) begin
                lfsr = next_rand(lfsr);
                mu = lfsr[12] && (i == 1 || i == 2);
                sel_case(i, mu, lfsr[9:0] & {mu, mu, m});
            end
            $display("done select mode %0d", i);
        end
        enc_case(2'b11, 2'b11, 8'h04, "fast forward");
        enc_case(2'b11, 2'b00, 8'h08, "backward");
        enc_case(2'b11, 2'b11, 8'h10, "slow forward");
        enc_case(2'b11, 2'b00, 8'h40, "crawl backward");
        enc_case(2'b11, 2'b01, 8'h10, "opposite turn");
        clear_fault();
        enc_case(2'b01, 2'b01, 8'h08, "one encoder dead");
        clear_fault();
        end_of_test();
    end
endmodule : area_select_tb
